/* File: ocd_defines.vh */
// Constants for the output current detection block
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCD_HI_LEVEL_ADDR 12'h000
`define OCD_HI_DELAY_ADDR 12'h004
`define OCD_ZERO_LEVEL_ADDR 12'h008
`define OCD_ZERO_TIME_ADDR 12'h00C
`define OCD_RETAIN_ADDR 12'h010
`define OCD_ACTION_ADDR 12'h014
`define OCD_SCOPE_ADDR 12'h018
`define OCD_CTRL_ADDR 12'h01C
`define OCD_STATUS_ADDR 12'h020
`define OCD_CURRENT_ADDR 12'h024
// ----------------------------------------
// Reset values, limits and codes (levels in 0.1 %, zero time in ticks, high delay and retain in steps of ten ticks)
// ----------------------------------------
`define OCD_HI_LEVEL_RST 16'h05DC
`define OCD_HI_DELAY_RST 16'h0000
`define OCD_ZERO_LEVEL_RST 16'h0032
`define OCD_ZERO_TIME_RST 16'h0032
`define OCD_RETAIN_RST 16'h0001
`define OCD_ACTION_RST 16'h0000
`define OCD_SCOPE_RST 16'h0000
`define OCD_LEVEL_MAX 16'h07D0
`define OCD_HI_DELAY_MAX 16'h0064
`define OCD_ZERO_TIME_MAX 16'h0064
`define OCD_RETAIN_MAX 16'h0064
`define OCD_HOLD_FOREVER 16'h270F
`define OCD_ACTION_TRIP 16'h0001
// ----------------------------------------
// Timing
// ----------------------------------------
`define OCD_CLK_HZ 20000000
`define OCD_TICK_MS 10
`define OCD_TICK_CYCLES ((`OCD_CLK_HZ / 1000) * `OCD_TICK_MS)
`define OCD_TICKS_PER_STEP 16'h000A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCD_ST_HI 0
`define OCD_ST_ZERO 1
`define OCD_ST_TRIP 2
`define OCD_ST_EXT 3
`define OCD_CTRL_START 0
`define OCD_CTRL_TRIPCLR 1
`endif

/* File: ocd_tick_gen.v */
// Fixed timebase tick generator
`timescale 1ns/1ns
module ocd_tick_gen #(
   parameter integer TICK_CYCLES = 200000
) (
   input wire pclk,
   input wire presetn,
   output reg tick
);
   reg [31:0] cnt_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt_reg >= TICK_CYCLES - 1) begin
         cnt_reg <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule

/* File: ocd_qual_timer.v */
// Tick counter that qualifies a condition held for a set time
`timescale 1ns/1ns
module ocd_qual_timer #(
   parameter integer W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire tick,
   input wire cond,
   input wire [W-1:0] limit,
   output reg done
);
   reg [W-1:0] cnt_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= {W{1'b0}};
         done <= 1'b0;
      end else if (!cond) begin
         cnt_reg <= {W{1'b0}};
         done <= 1'b0;
      end else if (cnt_reg >= limit) begin
         done <= 1'b1;
      end else if (tick) begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: ocd_top.v */
// Output current detection with APB parameter registers
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "ocd_defines.vh"
module ocd_top #(
   parameter integer TICK_CYCLES = `OCD_TICK_CYCLES
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] current_pin,
   input wire start_pin,
   output reg high_current_flag,
   output reg zero_current_flag,
   output reg current_detect_trip_fault,
   output reg extended_visible
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [15:0] cur_s1_reg;
   reg [15:0] cur_reg;
   reg start_s1_reg;
   reg start_s2_reg;
   reg start_d_reg;
   // Multi-bit current may skew across the two stages; the measurement
   // source is expected to hold each sample for many cycles.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_s1_reg <= 16'h0000;
         cur_reg <= 16'h0000;
         start_s1_reg <= 1'b0;
         start_s2_reg <= 1'b0;
         start_d_reg <= 1'b0;
      end else begin
         cur_s1_reg <= current_pin;
         cur_reg <= cur_s1_reg;
         start_s1_reg <= start_pin;
         start_s2_reg <= start_s1_reg;
         start_d_reg <= start_s2_reg;
      end
   end
   // ----------------------------------------
   // Parameter registers
   // ----------------------------------------
   reg [15:0] hi_level_reg;
   reg [15:0] hi_delay_reg;
   reg [15:0] zero_level_reg;
   reg [15:0] zero_time_reg;
   reg [15:0] retain_reg;
   reg [15:0] action_reg;
   reg [15:0] scope_reg;
   wire wr_acc = psel && penable && pwrite;
   wire sw_start = wr_acc && paddr == `OCD_CTRL_ADDR && pwdata[`OCD_CTRL_START];
   wire sw_tripclr = wr_acc && paddr == `OCD_CTRL_ADDR && pwdata[`OCD_CTRL_TRIPCLR];
   wire start_evt = (start_s2_reg && !start_d_reg) || sw_start;
   wire [15:0] wd = pwdata[15:0];
   // Out-of-range writes are refused so timers never see illegal settings
   wire lvl_ok = wd <= `OCD_LEVEL_MAX;
   wire dly_ok = wd <= `OCD_HI_DELAY_MAX;
   wire zt_ok = wd <= `OCD_ZERO_TIME_MAX;
   wire ret_ok = wd <= `OCD_RETAIN_MAX || wd == `OCD_HOLD_FOREVER;
   wire act_ok = wd <= `OCD_ACTION_TRIP;
   wire scp_ok = wd == 16'h0000 || wd == `OCD_HOLD_FOREVER;
   reg bad_wr;
   reg known;
   always @* begin
      known = 1'b1;
      bad_wr = 1'b0;
      case (paddr)
         `OCD_HI_LEVEL_ADDR: bad_wr = !lvl_ok;
         `OCD_HI_DELAY_ADDR: bad_wr = !dly_ok;
         `OCD_ZERO_LEVEL_ADDR: bad_wr = !lvl_ok;
         `OCD_ZERO_TIME_ADDR: bad_wr = !zt_ok;
         `OCD_RETAIN_ADDR: bad_wr = !ret_ok;
         `OCD_ACTION_ADDR: bad_wr = !act_ok;
         `OCD_SCOPE_ADDR: bad_wr = !scp_ok;
         `OCD_CTRL_ADDR: bad_wr = 1'b0;
         `OCD_STATUS_ADDR: bad_wr = 1'b1;
         `OCD_CURRENT_ADDR: bad_wr = 1'b1;
         default: known = 1'b0;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_level_reg <= `OCD_HI_LEVEL_RST;
         hi_delay_reg <= `OCD_HI_DELAY_RST;
         zero_level_reg <= `OCD_ZERO_LEVEL_RST;
         zero_time_reg <= `OCD_ZERO_TIME_RST;
         retain_reg <= `OCD_RETAIN_RST;
         action_reg <= `OCD_ACTION_RST;
         scope_reg <= `OCD_SCOPE_RST;
      end else if (wr_acc && known && !bad_wr) begin
         case (paddr)
            `OCD_HI_LEVEL_ADDR: hi_level_reg <= wd;
            `OCD_HI_DELAY_ADDR: hi_delay_reg <= wd;
            `OCD_ZERO_LEVEL_ADDR: zero_level_reg <= wd;
            `OCD_ZERO_TIME_ADDR: zero_time_reg <= wd;
            `OCD_RETAIN_ADDR: retain_reg <= wd;
            `OCD_ACTION_ADDR: action_reg <= wd;
            `OCD_SCOPE_ADDR: scope_reg <= wd;
            default: hi_level_reg <= hi_level_reg;
         endcase
      end
   end
   // ----------------------------------------
   // APB answer, zero wait states
   // ----------------------------------------
   reg [31:0] rd_next;
   always @* begin
      rd_next = 32'h00000000;
      case (paddr)
         `OCD_HI_LEVEL_ADDR: rd_next = {16'h0000, hi_level_reg};
         `OCD_HI_DELAY_ADDR: rd_next = {16'h0000, hi_delay_reg};
         `OCD_ZERO_LEVEL_ADDR: rd_next = {16'h0000, zero_level_reg};
         `OCD_ZERO_TIME_ADDR: rd_next = {16'h0000, zero_time_reg};
         `OCD_RETAIN_ADDR: rd_next = {16'h0000, retain_reg};
         `OCD_ACTION_ADDR: rd_next = {16'h0000, action_reg};
         `OCD_SCOPE_ADDR: rd_next = {16'h0000, scope_reg};
         `OCD_STATUS_ADDR: begin
            rd_next[`OCD_ST_HI] = high_current_flag;
            rd_next[`OCD_ST_ZERO] = zero_current_flag;
            rd_next[`OCD_ST_TRIP] = current_detect_trip_fault;
            rd_next[`OCD_ST_EXT] = extended_visible;
         end
         `OCD_CURRENT_ADDR: rd_next = {16'h0000, cur_reg};
         default: rd_next = 32'h00000000;
      endcase
   end
   // Answer is registered in setup so pready is high in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h00000000 : rd_next;
         pready <= 1'b1;
         pslverr <= !known || (pwrite && bad_wr);
      end else begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
   // ----------------------------------------
   // Detection timers
   // ----------------------------------------
   wire tick;
   wire hi_cond = cur_reg > hi_level_reg;
   wire zero_cond = cur_reg < zero_level_reg;
   wire hi_qual;
   wire zero_qual;
   ocd_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );
   // Delay setting is in 0.1 s, ten ticks each
   ocd_qual_timer #(.W(16)) u_hi_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .cond(hi_cond),
      .limit(hi_delay_reg * `OCD_TICKS_PER_STEP),
      .done(hi_qual)
   );
   ocd_qual_timer #(.W(16)) u_zero_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .cond(zero_cond),
      .limit(zero_time_reg),
      .done(zero_qual)
   );
   // ----------------------------------------
   // Flag retention and trip
   // ----------------------------------------
   reg [15:0] ret_cnt_reg;
   wire forever_hold = retain_reg == `OCD_HOLD_FOREVER;
   wire [15:0] ret_limit = retain_reg * `OCD_TICKS_PER_STEP;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_current_flag <= 1'b0;
         ret_cnt_reg <= 16'h0000;
      end else if (hi_qual && !start_evt) begin
         high_current_flag <= 1'b1;
         ret_cnt_reg <= 16'h0000;
      end else if (high_current_flag) begin
         if (forever_hold) begin
            if (start_evt) begin
               high_current_flag <= 1'b0;
            end
         end else if (ret_cnt_reg >= ret_limit) begin
            high_current_flag <= 1'b0;
         end else if (tick) begin
            ret_cnt_reg <= ret_cnt_reg + 16'h0001;
         end
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_current_flag <= 1'b0;
         current_detect_trip_fault <= 1'b0;
         extended_visible <= 1'b1;
      end else begin
         zero_current_flag <= zero_qual;
         // Action 0 never trips; the fault latches until cleared
         if (action_reg == `OCD_ACTION_TRIP && high_current_flag) begin
            current_detect_trip_fault <= 1'b1;
         end else if (sw_tripclr) begin
            current_detect_trip_fault <= 1'b0;
         end
         extended_visible <= scope_reg != `OCD_HOLD_FOREVER;
      end
   end
endmodule

/* File: ocd_sva.sv */
// Concurrent checks on the ports of the current detection block
`timescale 1ns/1ns
module ocd_sva (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] current_pin,
   input wire high_current_flag,
   input wire zero_current_flag,
   input wire current_detect_trip_fault,
   input wire extended_visible
);
   // ----------------------------------------
   // Bus and flag properties
   // ----------------------------------------
   wire acc = psel && penable;
   wire clr = acc && pwrite && paddr == 12'h01C && pwdata[1];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_PREADY: assert property (acc |-> pready) else $error("pready low in access");
   AST_IDLE: assert property (!acc |-> prdata == 32'h0 && !pready) else $error("idle bus busy");
   AST_UPPER: assert property (acc |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
   AST_CTRL_RD: assert property (acc && !pwrite && paddr == 12'h01C |-> prdata == 32'h0)
      else $error("control read not zero");
   AST_BAD_WR: assert property (
      acc && pwrite && paddr == 12'h000 && pwdata[15:0] > 16'h07D0 |-> pslverr)
      else $error("range error missing");
   AST_TRIP_CAUSE: assert property (
      $rose(current_detect_trip_fault) |-> $past(high_current_flag))
      else $error("trip without flag");
   AST_TRIP_HOLD: assert property (
      current_detect_trip_fault && !clr |=> current_detect_trip_fault)
      else $error("trip lost");
   AST_NO_ZERO: assert property (
      (current_pin > 16'h07D0) [*8] |-> !zero_current_flag) else $error("zero flag at high current");
   AST_NO_HIGH: assert property (
      (current_pin == 16'h0000) [*8] |-> !$rose(high_current_flag))
      else $error("high flag at no current");
   AST_SCOPE: assert property (
      acc && pwrite && paddr == 12'h018 && pwdata[15:0] == 16'h270F |-> ##[1:3] !extended_visible)
      else $error("extended view kept");
endmodule
bind ocd_top ocd_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .current_pin, .high_current_flag, .zero_current_flag,
   .current_detect_trip_fault, .extended_visible);

/* File: ocd_drive_model.sv */
// Measured current and start command source of the drive
`timescale 1ns/1ns
module ocd_drive_model (
   input wire pclk,
   input wire [15:0] level_cmd,
   input wire start_cmd,
   output reg [15:0] current_pin,
   output reg start_pin
);
   // Values change only after an edge, as a sampled measurement would
   initial begin
      current_pin = 16'h0000;
      start_pin = 1'b0;
   end
   always @(posedge pclk) begin
      current_pin <= level_cmd;
      start_pin <= start_cmd;
   end
endmodule

/* File: output_current_detection_test.sv */
// Self-checking bench for the output current detection block
`timescale 1ns/1ns
`include "ocd_defines.vh"
module output_current_detection_test;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   reg pclk, presetn, psel, penable, pwrite, st, er;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd;
   reg [15:0] cur;
   wire [31:0] prdata;
   wire pready, pslverr, hi, zf, trip, ext, start_pin;
   wire [15:0] current_pin;
   integer err_count, num_checks;
   // Short tick keeps second-scale timers inside the run
   ocd_top #(.TICK_CYCLES(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .current_pin, .start_pin, .high_current_flag(hi),
      .zero_current_flag(zf), .current_detect_trip_fault(trip), .extended_visible(ext));
   ocd_drive_model i_drv (.pclk, .level_cmd(cur), .start_cmd(st), .current_pin, .start_pin);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task cyc(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, exp, rd);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      begin
         rchk("hi_level", `OCD_HI_LEVEL_ADDR, 32'h000005DC);
         rchk("hi_delay", `OCD_HI_DELAY_ADDR, 32'h00000000);
         rchk("zero_level", `OCD_ZERO_LEVEL_ADDR, 32'h00000032);
         rchk("zero_time", `OCD_ZERO_TIME_ADDR, 32'h00000032);
         rchk("retain", `OCD_RETAIN_ADDR, 32'h00000001);
         rchk("action", `OCD_ACTION_ADDR, 32'h00000000);
         rchk("scope", `OCD_SCOPE_ADDR, 32'h00000000);
         apb(1'b1, `OCD_HI_LEVEL_ADDR, 32'h000007D1);
         chk("range_err", 32'h1, {31'h0, er});
         rchk("hi_level", `OCD_HI_LEVEL_ADDR, 32'h000005DC);
         apb(1'b0, 12'h03C, 32'h0);
         chk("unmapped_err", 32'h1, {31'h0, er});
         chk("unmapped_rd", 32'h0, rd);
         apb(1'b1, `OCD_STATUS_ADDR, 32'h0);
         chk("ro_err", 32'h1, {31'h0, er});
      end
   endtask
   task t_zero;
      begin
         cur <= 16'h0064;
         apb(1'b1, `OCD_ZERO_TIME_ADDR, 32'h00000005);
         cyc(8);
         cur <= 16'h001E;
         cyc(60);
         chk("zero_early", 32'h0, {31'h0, zf});
         cyc(70);
         chk("zero_on", 32'h1, {31'h0, zf});
         cur <= 16'h0064;
         cyc(8);
         chk("zero_off", 32'h0, {31'h0, zf});
      end
   endtask
   task t_high;
      begin
         apb(1'b1, `OCD_HI_LEVEL_ADDR, 32'h000003E8);
         apb(1'b1, `OCD_HI_DELAY_ADDR, 32'h00000001);
         cur <= 16'h044C;
         cyc(150);
         chk("hi_early", 32'h0, {31'h0, hi});
         cyc(100);
         chk("hi_on", 32'h1, {31'h0, hi});
         chk("no_trip", 32'h0, {31'h0, trip});
         rchk("current", `OCD_CURRENT_ADDR, 32'h0000044C);
         cur <= 16'h01F4;
         cyc(150);
         chk("hi_held", 32'h1, {31'h0, hi});
         cyc(110);
         chk("hi_off", 32'h0, {31'h0, hi});
      end
   endtask
   task t_latch;
      begin
         apb(1'b1, `OCD_RETAIN_ADDR, 32'h0000270F);
         apb(1'b1, `OCD_ACTION_ADDR, 32'h00000001);
         cur <= 16'h0834;
         cyc(260);
         chk("trip_on", 32'h1, {31'h0, trip});
         cur <= 16'h0000;
         cyc(400);
         chk("hi_latched", 32'h1, {31'h0, hi});
         rchk("status", `OCD_STATUS_ADDR, 32'h0000000F);
         st <= 1'b1;
         cyc(4);
         st <= 1'b0;
         cyc(4);
         chk("hi_started", 32'h0, {31'h0, hi});
         apb(1'b1, `OCD_CTRL_ADDR, 32'h00000002);
         chk("trip_clr", 32'h0, {31'h0, trip});
         apb(1'b1, `OCD_HI_DELAY_ADDR, 32'h00000000);
         cur <= 16'h0834;
         cyc(10);
         chk("hi_nodelay", 32'h1, {31'h0, hi});
         cur <= 16'h0000;
         cyc(10);
         apb(1'b1, `OCD_CTRL_ADDR, 32'h00000001);
         chk("hi_sw_start", 32'h0, {31'h0, hi});
      end
   endtask
   task t_scope;
      begin
         chk("ext_dflt", 32'h1, {31'h0, ext});
         apb(1'b1, `OCD_SCOPE_ADDR, 32'h0000270F);
         cyc(2);
         chk("ext_simple", 32'h0, {31'h0, ext});
         apb(1'b1, `OCD_SCOPE_ADDR, 32'h00000000);
         cyc(2);
         chk("ext_full", 32'h1, {31'h0, ext});
      end
   endtask
   task end_of_test;
      begin
         if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Sequence and watchdog
   // ----------------------------------------
   initial begin
      err_count = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cur = 16'h0000;
      st = 1'b0;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      t_scope;
      t_regs;
      t_zero;
      t_high;
      t_latch;
      end_of_test;
   end
   initial begin
      cyc(20000);
      err_count = err_count + 1;
      end_of_test;
   end
endmodule
